// ===== core/adcsf_pkg.sv
// shared constants and types for the converter status-flag block
package adcsf_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int CH_W   = 3;
    localparam int DATA_W = 10;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_MODE     = 8'h04;
    localparam logic [7:0] OFS_CHEN     = 8'h10;
    localparam logic [7:0] OFS_CHDIS    = 8'h14;
    localparam logic [7:0] OFS_CHSR     = 8'h18;
    localparam logic [7:0] OFS_STAT     = 8'h1C;
    localparam logic [7:0] OFS_LAST     = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_ID       = 8'h2C;
    localparam logic [7:0] OFS_CDR_BASE = 8'h30;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int MODE_SLEEP_BIT = 0;
    localparam int STAT_CHANNEL_OVERRUN_FLAG_LSB  = 8;
    localparam int STAT_RESULT_READY_FLAG_BIT  = 16;
    localparam int STAT_ANY_OVERRUN_FLAG_BIT = 17;
    localparam int STAT_BUSY_BIT  = 18;
    localparam int LAST_CHAN_LSB  = 12;
    localparam int IRQ_W          = 3;
    localparam int IRQ_READY_BIT  = 0;
    localparam int IRQ_GOVR_BIT   = 1;
    localparam int IRQ_COVR_BIT   = 2;

    // arbitrary identification value
    localparam logic [31:0] ID_VALUE = 32'h0000_5A01;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // converter handshake carrier
    typedef struct packed {
        logic              done;
        logic [DATA_W-1:0] data;
    } adcsf_result_t;

    typedef struct packed {
        logic            start;
        logic [CH_W-1:0] chan;
    } adcsf_request_t;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_START = 3'b010,
        SEQ_WAIT  = 3'b100
    } adcsf_seq_t;

endpackage : adcsf_pkg

// ===== core/adcsf_chan_flags.sv
// per-channel end-of-conversion and overrun flags
`timescale 1ns/1ps
module adcsf_chan_flags (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic done_here,
    input  wire logic clear_eoc,
    input  wire logic read_status,
    output logic      eoc,
    output logic      channel_overrun_flag
);

    // a fresh result wins over a read clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eoc <= 1'b0;
        end else if (done_here) begin
            eoc <= 1'b1;
        end else if (clear_eoc) begin
            eoc <= 1'b0;
        end
    end

    // only a completion over a still-set done flag is an overrun, so a
    // status read clears overrun even when done is set afresh
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_overrun_flag <= 1'b0;
        end else if (done_here && eoc) begin
            channel_overrun_flag <= 1'b1;
        end else if (read_status) begin
            channel_overrun_flag <= 1'b0;
        end
    end

endmodule : adcsf_chan_flags

// ===== core/adcsf_ctrl.sv
// converter result and status-flag controller with AHB-Lite registers
`timescale 1ns/1ps
module adcsf_ctrl #(
    parameter int NCH = 8
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire adcsf_pkg::adcsf_result_t conv_result,
    output adcsf_pkg::adcsf_request_t   conv_request,
    output logic                        sleep_mode,
    output logic                        irq
);

    localparam int CW = adcsf_pkg::CH_W;
    localparam int DW = adcsf_pkg::DATA_W;

    // ---------------------------------------------------------------
    // bus access decode
    // ---------------------------------------------------------------
    logic          acc;
    logic          rd;
    logic [7:0]    ofs;
    logic          rd_stat;
    logic          rd_last;
    logic          rd_cdr;
    logic [7:0]    cdr_ofs;
    logic [CW-1:0] cdr_idx;
    logic          wr_pend;
    logic [7:0]    wr_ofs;

    assign acc     = hsel && hready && (htrans == adcsf_pkg::HTRANS_NONSEQ);
    assign rd      = acc && !hwrite;
    assign ofs     = haddr[7:0];
    assign rd_stat = rd && (ofs == adcsf_pkg::OFS_STAT);
    assign rd_last = rd && (ofs == adcsf_pkg::OFS_LAST);
    assign cdr_ofs = ofs - adcsf_pkg::OFS_CDR_BASE;
    assign cdr_idx = cdr_ofs[CW+1:2];
    assign rd_cdr  = rd && (ofs >= adcsf_pkg::OFS_CDR_BASE)
                     && (cdr_ofs[7:2] < 6'(NCH));

    // writes complete in the data phase, when hwdata is valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs  <= 8'h00;
        end else begin
            wr_pend <= acc && hwrite;
            wr_ofs  <= ofs;
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_chen;
    logic wr_chdis;
    assign wr_ctrl  = wr_pend && (wr_ofs == adcsf_pkg::OFS_CTRL);
    assign wr_chen  = wr_pend && (wr_ofs == adcsf_pkg::OFS_CHEN);
    assign wr_chdis = wr_pend && (wr_ofs == adcsf_pkg::OFS_CHDIS);

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    localparam int IRQ_W_L = adcsf_pkg::IRQ_W;
    logic           mode_sleep;
    logic [NCH-1:0] chen;
    logic [IRQ_W_L-1:0] irq_mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_sleep <= 1'b0;
            irq_mask   <= '0;
        end else if (wr_pend && wr_ofs == adcsf_pkg::OFS_MODE) begin
            mode_sleep <= hwdata[adcsf_pkg::MODE_SLEEP_BIT];
        end else if (wr_pend && wr_ofs == adcsf_pkg::OFS_IRQ_MASK) begin
            irq_mask <= hwdata[IRQ_W_L-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chen <= '0;
        end else if (wr_chen) begin
            chen <= chen | hwdata[NCH-1:0];
        end else if (wr_chdis) begin
            chen <= chen & ~hwdata[NCH-1:0];
        end
    end

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    adcsf_pkg::adcsf_seq_t seq;
    logic [NCH-1:0] pend;
    logic [CW-1:0]  cur_ch;
    logic           killed;
    logic [CW-1:0]  first_ch;
    logic           go;

    assign go = wr_ctrl && hwdata[adcsf_pkg::CTRL_START_BIT];

    always_comb begin
        first_ch = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pend[i]) begin
                first_ch = CW'(i);
            end
        end
    end

    // a start while busy is ignored; channels convert lowest first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq          <= adcsf_pkg::SEQ_IDLE;
            pend         <= '0;
            cur_ch       <= '0;
            conv_request <= '0;
        end else begin
            conv_request.start <= 1'b0;
            case (seq)
                adcsf_pkg::SEQ_IDLE: begin
                    if (go && chen != '0) begin
                        pend <= chen;
                        seq  <= adcsf_pkg::SEQ_START;
                    end
                end
                adcsf_pkg::SEQ_START: begin
                    cur_ch             <= first_ch;
                    conv_request.chan  <= first_ch;
                    conv_request.start <= 1'b1;
                    pend[first_ch]     <= 1'b0;
                    seq                <= adcsf_pkg::SEQ_WAIT;
                end
                adcsf_pkg::SEQ_WAIT: begin
                    if (conv_result.done) begin
                        seq <= (pend != '0) ? adcsf_pkg::SEQ_START
                                            : adcsf_pkg::SEQ_IDLE;
                    end
                end
                default: begin
                    seq <= adcsf_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // remember a disable that lands on the running channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            killed <= 1'b0;
        end else if (seq == adcsf_pkg::SEQ_START) begin
            killed <= 1'b0;
        end else if (wr_chdis && hwdata[cur_ch]) begin
            killed <= 1'b1;
        end
    end

    // selecting sleep while idle does nothing until a conversion ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_mode <= 1'b0;
        end else if (go) begin
            sleep_mode <= 1'b0;
        end else if (seq == adcsf_pkg::SEQ_WAIT && conv_result.done) begin
            sleep_mode <= mode_sleep;
        end
    end

    // ---------------------------------------------------------------
    // result storage and flags
    // ---------------------------------------------------------------
    logic           store;
    logic [DW-1:0]  per_channel_result [NCH];
    logic [DW-1:0]  last_data;
    logic [CW-1:0]  last_ch;
    logic           result_ready_flag;
    logic           any_overrun_flag;
    logic [NCH-1:0] eoc;
    logic [NCH-1:0] channel_overrun_flag;

    // disabling some other channel never gates the store
    assign store = (seq == adcsf_pkg::SEQ_WAIT) && conv_result.done
                   && chen[cur_ch] && !killed;

    always_ff @(posedge hclk) begin
        if (store) begin
            per_channel_result[cur_ch] <= conv_result.data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_data <= '0;
            last_ch   <= '0;
        end else if (store) begin
            last_data <= conv_result.data;
            last_ch   <= cur_ch;
        end
    end

    // channel result reads leave data-ready alone; set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ready_flag <= 1'b0;
        end else if (store) begin
            result_ready_flag <= 1'b1;
        end else if (rd_last) begin
            result_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            any_overrun_flag <= 1'b0;
        end else if (store && result_ready_flag) begin
            any_overrun_flag <= 1'b1;
        end else if (rd_stat) begin
            any_overrun_flag <= 1'b0;
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_chan
        logic clr;
        assign clr = (rd_cdr && cdr_idx == CW'(g))
                     || (rd_last && last_ch == CW'(g));
        adcsf_chan_flags u_flags (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .done_here   (store && cur_ch == CW'(g)),
            .clear_eoc   (clr),
            .read_status (rd_stat),
            .eoc         (eoc[g]),
            .channel_overrun_flag        (channel_overrun_flag[g])
        );
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    logic [IRQ_W_L-1:0] irq_stat;
    logic [IRQ_W_L-1:0] irq_set;

    always_comb begin
        irq_set = '0;
        irq_set[adcsf_pkg::IRQ_READY_BIT] = store;
        irq_set[adcsf_pkg::IRQ_GOVR_BIT]  = store && result_ready_flag;
        irq_set[adcsf_pkg::IRQ_COVR_BIT]  = store && eoc[cur_ch];
    end

    // write one to clear; a new event in the same cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else if (wr_pend && wr_ofs == adcsf_pkg::OFS_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[IRQ_W_L-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ---------------------------------------------------------------
    // read data, registered in the address phase
    // ---------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!rd) begin
            next_rdata = 32'h0000_0000;
        end else if (ofs == adcsf_pkg::OFS_MODE) begin
            next_rdata[adcsf_pkg::MODE_SLEEP_BIT] = mode_sleep;
        end else if (ofs == adcsf_pkg::OFS_CHSR) begin
            next_rdata[NCH-1:0] = chen;
        end else if (ofs == adcsf_pkg::OFS_STAT) begin
            next_rdata[NCH-1:0] = eoc;
            next_rdata[adcsf_pkg::STAT_CHANNEL_OVERRUN_FLAG_LSB +: NCH] = channel_overrun_flag;
            next_rdata[adcsf_pkg::STAT_RESULT_READY_FLAG_BIT]  = result_ready_flag;
            next_rdata[adcsf_pkg::STAT_ANY_OVERRUN_FLAG_BIT] = any_overrun_flag;
            next_rdata[adcsf_pkg::STAT_BUSY_BIT]  =
                (seq != adcsf_pkg::SEQ_IDLE);
        end else if (ofs == adcsf_pkg::OFS_LAST) begin
            next_rdata[DW-1:0] = last_data;
            next_rdata[adcsf_pkg::LAST_CHAN_LSB +: CW] = last_ch;
        end else if (ofs == adcsf_pkg::OFS_IRQ_STAT) begin
            next_rdata[IRQ_W_L-1:0] = irq_stat;
        end else if (ofs == adcsf_pkg::OFS_IRQ_MASK) begin
            next_rdata[IRQ_W_L-1:0] = irq_mask;
        end else if (ofs == adcsf_pkg::OFS_ID) begin
            next_rdata = adcsf_pkg::ID_VALUE;
        end else if (rd_cdr) begin
            next_rdata[DW-1:0] = per_channel_result[cdr_idx];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ready_on_store: assert property (store |=> result_ready_flag)
        else $error("data-ready not set by stored result");
    a_ready_holds: assert property (
        result_ready_flag && !rd_last |=> result_ready_flag)
        else $error("data-ready cleared without last-result read");
    a_ready_disabled: assert property (
        !result_ready_flag && !store |=> !result_ready_flag)
        else $error("data-ready set with no stored result");
    a_any_overrun_flag_sets: assert property (
        store && result_ready_flag |=> any_overrun_flag && result_ready_flag)
        else $error("general overrun not set");
    a_any_overrun_flag_read: assert property (
        rd_stat && !(store && result_ready_flag) |=> !any_overrun_flag)
        else $error("general overrun not cleared by status read");
    a_channel_overrun_flag_read: assert property (
        rd_stat && !store |=> channel_overrun_flag == '0)
        else $error("channel overrun survived status read");
    a_channel_overrun_flag_sets: assert property (
        store && eoc[cur_ch] |=> channel_overrun_flag[$past(cur_ch)])
        else $error("channel overrun not set");
    a_eoc_own_clear: assert property (
        rd_cdr && !store && !rd_last |=>
        eoc == ($past(eoc) & ~(NCH'(1) << $past(cdr_idx))))
        else $error("wrong done flag cleared");
    a_eoc_no_spur: assert property (
        !store |=> (eoc & ~$past(eoc)) == '0)
        else $error("done flag raised without stored result");
    a_sleep_at_end: assert property (
        $rose(sleep_mode) |-> $past(conv_result.done)
        && $past(seq == adcsf_pkg::SEQ_WAIT))
        else $error("sleep entered outside a conversion end");
    a_irq_level: assert property (
        ##1 irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt output mismatch");

endmodule : adcsf_ctrl

// ===== verification/adc_result_status_flags_tb.sv
// self-checking bench for the converter status-flag controller
`timescale 1ns/1ps
module adc_result_status_flags_tb;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam logic [31:0] SM = 32'h0003_FFFF;
    localparam logic [31:0] LM = 32'h0000_73FF;
    localparam logic [31:0] DM = 32'h0000_03FF;
    logic                       hclk;
    logic                       hresetn;
    logic                       hsel;
    logic [31:0]                haddr;
    logic [1:0]                 htrans;
    logic                       hwrite;
    logic [2:0]                 hsize;
    logic [31:0]                hwdata;
    wire logic                  hready;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    adcsf_pkg::adcsf_result_t   conv_result;
    adcsf_pkg::adcsf_request_t  conv_request;
    logic                       sleep_mode;
    logic                       irq;
    logic [31:0]                eq[$];
    logic [31:0]                mq[$];
    logic                       rd_dp;
    logic [31:0]                seed;
    logic [9:0]                 cdata;
    logic [9:0]                 dv[2];
    int                         errors;
    int                         check_count;
    int                         nstart = 0;
    int                         took;
    logic [2:0]                 start_ch;

    // bus is single-slave, so its ready is the slave's own
    assign hready = hreadyout;

    adcsf_ctrl #(.NCH(8)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .conv_result(conv_result), .conv_request(conv_request),
        .sleep_mode(sleep_mode), .irq(irq)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    function automatic logic [31:0] st(input logic [7:0] e,
                                       input logic [7:0] o,
                                       input logic r, input logic g);
        return {14'h0, g, r, o, e};
    endfunction : st

    function automatic logic [31:0] lst(input logic [2:0] c,
                                        input logic [9:0] d);
        return {17'h0, c, 2'h0, d};
    endfunction : lst

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // cd 1 ends a conversion at the address edge, cd 2 at the data edge
    task automatic op(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m,
                      input int cd);
        if (!w) begin
            eq.push_back(d & m);
            mq.push_back(m);
        end
        hsel <= 1'b1;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= adcsf_pkg::HTRANS_NONSEQ;
        conv_result.data <= cdata;
        if (cd == 1) conv_result.done <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        if (cd != 0) conv_result.done <= (cd == 2);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        if (cd == 2) conv_result.done <= 1'b0;
    endtask : op

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        op(1'b0, a, e, m, 0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        op(1'b1, a, d, 32'h0, 0);
    endtask : wr

    task automatic wstart(input logic [2:0] ch);
        int n;
        n = 0;
        while (nstart == took && n < 200) begin
            @(posedge hclk);
            n++;
        end
        chk({28'h0, nstart != took, start_ch}, {28'h0, 1'b1, ch});
        took = nstart;
        seed = xs(seed);
        cdata = seed[9:0];
    endtask : wstart

    task automatic conv(input logic [2:0] ch, input logic w,
                        input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] m, input int cd);
        wstart(ch);
        if (cd == 0) begin
            conv_result.data <= cdata;
            conv_result.done <= 1'b1;
            @(posedge hclk);
            conv_result.done <= 1'b0;
        end else begin
            op(w, a, d, m, cd);
        end
        dv[ch[0]] = cdata;
    endtask : conv

    // ---------------------------------------------------------------
    // clock, read-data watcher, watchdog
    // ---------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // the start pulse lasts one cycle, so it is latched while a bus
    // transfer keeps the main sequence busy
    always @(posedge hclk) begin
        if (conv_request.start === 1'b1) begin
            nstart <= nstart + 1;
            start_ch <= conv_request.chan;
        end
        if (rd_dp && hreadyout === 1'b1) begin
            chk({31'h0, hresp}, 32'h0);
            if (eq.size() == 0) begin
                chk(32'h0, 32'h1);
            end else begin
                chk(hrdata & mq[0], eq[0]);
                void'(eq.pop_front());
                void'(mq.pop_front());
            end
        end
        rd_dp <= hsel && htrans == adcsf_pkg::HTRANS_NONSEQ && !hwrite
                 && hreadyout;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        test_done();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        conv_result = '0;
        rd_dp = 1'b0;
        seed = 32'hDD93;
        cdata = 10'h0;
        errors = 0;
        check_count = 0;
        took = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(adcsf_pkg::OFS_STAT, 32'h0, '1);
        rd(adcsf_pkg::OFS_CHSR, 32'h0, '1);
        rd(adcsf_pkg::OFS_MODE, 32'h0, '1);
        rd(adcsf_pkg::OFS_IRQ_MASK, 32'h0, '1);
        rd(adcsf_pkg::OFS_ID, adcsf_pkg::ID_VALUE, '1);
        rd(8'h80, 32'h0, '1);
        wr(adcsf_pkg::OFS_IRQ_MASK, 32'h7);
        wr(adcsf_pkg::OFS_CHEN, 32'h3);
        rd(adcsf_pkg::OFS_CHSR, 32'h3, 32'hFF);
        // first scan: both results left unread
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        conv(0, 1'b0, 8'h0, 32'h0, 32'h0, 0);
        conv(1, 1'b0, 8'h0, 32'h0, 32'h0, 0);
        rd(adcsf_pkg::OFS_STAT, st(8'h3, 8'h0, 1, 1), SM);
        rd(adcsf_pkg::OFS_STAT, st(8'h3, 8'h0, 1, 0), SM);
        rd(adcsf_pkg::OFS_LAST, lst(1, dv[1]), LM);
        rd(adcsf_pkg::OFS_STAT, st(8'h1, 8'h0, 0, 0), SM);
        // second scan: completions meet channel result reads
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        conv(0, 1'b0, adcsf_pkg::OFS_CDR_BASE + 8'h4, dv[1], DM, 1);
        rd(adcsf_pkg::OFS_STAT, st(8'h1, 8'h1, 1, 0), SM);
        conv(1, 1'b0, adcsf_pkg::OFS_CDR_BASE, dv[0], DM, 1);
        rd(adcsf_pkg::OFS_STAT, st(8'h2, 8'h0, 1, 1), SM);
        // third scan: status read and channel disable at completion
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        conv(0, 1'b0, adcsf_pkg::OFS_STAT, st(8'h2, 8'h0, 1, 0), SM, 1);
        rd(adcsf_pkg::OFS_STAT, st(8'h3, 8'h0, 1, 1), SM);
        rd(adcsf_pkg::OFS_STAT, st(8'h3, 8'h0, 1, 0), SM);
        conv(1, 1'b1, adcsf_pkg::OFS_CHDIS, 32'h1, 32'h0, 2);
        rd(adcsf_pkg::OFS_STAT, st(8'h3, 8'h2, 1, 1), SM);
        rd(adcsf_pkg::OFS_LAST, lst(1, dv[1]), LM);
        rd(adcsf_pkg::OFS_CHSR, 32'h2, 32'hFF);
        rd(adcsf_pkg::OFS_STAT, st(8'h1, 8'h0, 0, 0), SM);
        // fourth scan: running channel disabled, ends under a last read
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        wstart(1);
        wr(adcsf_pkg::OFS_CHDIS, 32'h2);
        op(1'b0, adcsf_pkg::OFS_LAST, lst(1, dv[1]), LM, 1);
        rd(adcsf_pkg::OFS_STAT, st(8'h1, 8'h0, 0, 0), SM);
        rd(adcsf_pkg::OFS_LAST, lst(1, dv[1]), LM);
        // sleep selected while idle waits for a conversion end
        wr(adcsf_pkg::OFS_MODE, 32'h1);
        repeat (4) @(posedge hclk);
        chk({31'h0, sleep_mode}, 32'h0);
        wr(adcsf_pkg::OFS_CHEN, 32'h1);
        rd(adcsf_pkg::OFS_MODE, 32'h1, 32'h1);
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        wstart(0);
        chk({31'h0, sleep_mode}, 32'h0);
        conv_result.data <= cdata;
        conv_result.done <= 1'b1;
        @(posedge hclk);
        conv_result.done <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({31'h0, sleep_mode}, 32'h1);
        // overrun set, done cleared, then a status read meets a completion
        rd(adcsf_pkg::OFS_CDR_BASE, {22'h0, cdata}, DM);
        wr(adcsf_pkg::OFS_CTRL, 32'h1);
        wstart(0);
        op(1'b0, adcsf_pkg::OFS_STAT, st(8'h0, 8'h1, 1, 0), SM, 1);
        rd(adcsf_pkg::OFS_STAT, st(8'h1, 8'h0, 1, 1), SM);
        // interrupt: raised, masked, cleared
        rd(adcsf_pkg::OFS_IRQ_STAT, 32'h7, 32'h7);
        chk({31'h0, irq}, 32'h1);
        wr(adcsf_pkg::OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(adcsf_pkg::OFS_IRQ_MASK, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(adcsf_pkg::OFS_IRQ_STAT, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rd(adcsf_pkg::OFS_IRQ_STAT, 32'h0, 32'h7);
        // let the watcher take the last read before the verdict
        repeat (2) @(posedge hclk);
        test_done();
    end
endmodule : adc_result_status_flags_tb
